// [spidb_map.vh]
`ifndef SPIDB_MAP_VH
`define SPIDB_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPIDB_OFS_TX 8'h29
`define SPIDB_OFS_RX 8'h2A
`define SPIDB_OFS_CTRL 8'h2B
`define SPIDB_OFS_ISTAT 8'h2C
`define SPIDB_OFS_IMASK 8'h2D

// ----------------------------------------
// Control and status fields
// ----------------------------------------
`define SPIDB_CTRL_EN 0
`define SPIDB_CTRL_MST 1
`define SPIDB_CTRL_TXE 3
`define SPIDB_CTRL_RXF 4
`define SPIDB_CTRL_BUSY 5

// ----------------------------------------
// Interrupt fields
// ----------------------------------------
`define SPIDB_INT_TX 0
`define SPIDB_INT_RX 1
`define SPIDB_INT_OVR 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPIDB_RST_BYTE 8'h00
`define SPIDB_RST_INT 3'h0
`define SPIDB_RST_EN 1'b0
`define SPIDB_RST_MST 1'b0
`define SPIDB_RST_TXE 1'b1
`define SPIDB_RST_RXF 1'b0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SPIDB_CLK_MHZ 20
`define SPIDB_HALF_NS 500
`define SPIDB_HALF_CYC ((`SPIDB_HALF_NS * `SPIDB_CLK_MHZ + 999) / 1000)
`define SPIDB_BITS 8

`endif

// [spidb_sync.v]
// ----------------------------------------
// Three stage pin synchroniser
// ----------------------------------------
module spidb_sync #(
    parameter RST_VAL = 1'b0
) (
    input wire clk,
    input wire rstn,
    input wire din,
    output reg dout
);

reg s1;
reg s2;
reg s3;

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        s1 <= RST_VAL;
        s2 <= RST_VAL;
        s3 <= RST_VAL;
        dout <= RST_VAL;
    end else begin
        s1 <= din;
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
            dout <= s3;
        end
    end
end

endmodule // spidb_sync

// [spidb_shift.v]
// ----------------------------------------
// Eight bit shifter, MSB first
// ----------------------------------------
module spidb_shift (
    input wire clk,
    input wire rstn,
    input wire load,
    input wire [7:0] din,
    input wire sample,
    input wire drive,
    input wire sin,
    output reg sout,
    output reg [7:0] data,
    output wire last,
    output reg done
);

reg [2:0] cnt;

assign last = (cnt == 3'h7);

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        data <= 8'h00;
        sout <= 1'b0;
        cnt <= 3'h0;
        done <= 1'b0;
    end else begin
        done <= 1'b0;
        if (load) begin
            data <= din;
            sout <= din[7];
            cnt <= 3'h0;
        end else begin
            if (sample) begin
                data <= {data[6:0], sin};
                cnt <= cnt + 3'h1;
                done <= last;
            end
            if (drive) begin
                sout <= sample ? data[6] : data[7];
            end
        end
    end
end

endmodule // spidb_shift

// [spidb_top.v]
// Chosen here: the plain strobed port.
`include "spidb_map.vh"

module spidb_top (
    input wire CLK_SYS,
    input wire RSTN,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output wire [7:0] RDATA,
    output wire IRQ,
    input wire SCLK_I,
    output wire SCLK_O,
    output wire SCLK_OE_N,
    input wire MOSI_I,
    output wire MOSI_O,
    output wire MOSI_OE_N,
    input wire MISO_I,
    output wire MISO_O,
    output wire MISO_OE_N,
    input wire SS_N_I,
    output wire SS_N_O,
    output wire SS_N_OE_N
);

// ----------------------------------------
// Constants
// ----------------------------------------
localparam [31:0] HALF_CYC = `SPIDB_HALF_CYC;
localparam [1:0] M_IDLE = 2'h0;
localparam [1:0] M_LOW = 2'h1;
localparam [1:0] M_HIGH = 2'h2;
localparam [1:0] M_END = 2'h3;

// ----------------------------------------
// Declarations
// ----------------------------------------
reg ctrl_en;
reg ctrl_mst;
reg [7:0] tx_buf;
reg tx_empty;
reg [7:0] rx_buf;
reg rx_full;
reg [2:0] int_stat;
reg [2:0] int_mask;
reg [7:0] rdata;
reg [1:0] m_state;
reg [1:0] next_state;
reg [3:0] m_cnt;
reg sclk_out;
reg ss_out;
reg m_load;
reg m_sample;
reg p_sclk;
reg p_ss_n;
wire s_sclk;
wire s_mosi;
wire s_miso;
wire s_ss_n;
wire wr_tx;
wire wr_rx;
wire rd_rx;
wire wr_ctrl;
wire wr_istat;
wire wr_imask;
wire m_act;
wire s_act;
wire sel;
wire half_end;
wire s_load;
wire s_sample;
wire s_drive;
wire sh_load;
wire sh_sample;
wire sh_drive;
wire sh_sin;
wire sh_sout;
wire [7:0] sh_data;
wire sh_last;
wire sh_done;
wire busy;
wire ev_tx;
wire ev_rx;
wire ev_ovr;
wire [2:0] int_set;
wire [7:0] ctrl_view;

// ----------------------------------------
// Address decode
// ----------------------------------------
assign wr_tx = WR && (ADDR == `SPIDB_OFS_TX);
assign wr_rx = WR && (ADDR == `SPIDB_OFS_RX);
assign rd_rx = RD && (ADDR == `SPIDB_OFS_RX);
assign wr_ctrl = WR && (ADDR == `SPIDB_OFS_CTRL);
assign wr_istat = WR && (ADDR == `SPIDB_OFS_ISTAT);
assign wr_imask = WR && (ADDR == `SPIDB_OFS_IMASK);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
spidb_sync #(
    .RST_VAL(1'b0)
) u_sync_sclk (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .din(SCLK_I),
    .dout(s_sclk)
);

spidb_sync #(
    .RST_VAL(1'b0)
) u_sync_mosi (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .din(MOSI_I),
    .dout(s_mosi)
);

spidb_sync #(
    .RST_VAL(1'b0)
) u_sync_miso (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .din(MISO_I),
    .dout(s_miso)
);

spidb_sync #(
    .RST_VAL(1'b1)
) u_sync_ss (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .din(SS_N_I),
    .dout(s_ss_n)
);

// ----------------------------------------
// Role selection
// ----------------------------------------
assign m_act = ctrl_en && ctrl_mst;
assign s_act = ctrl_en && !ctrl_mst;
assign sel = s_act && !s_ss_n;
assign busy = (m_state != M_IDLE) || sel;

// ----------------------------------------
// Master sequencer
// ----------------------------------------
assign half_end = (m_cnt == HALF_CYC[3:0] - 4'h1);

always @* begin
    next_state = m_state;
    m_load = 1'b0;
    m_sample = 1'b0;
    case (m_state)
        M_IDLE: begin
            if (m_act && !tx_empty) begin
                m_load = 1'b1;
                next_state = M_LOW;
            end
        end
        M_LOW: begin
            if (!m_act) begin
                next_state = M_IDLE;
            end else if (half_end) begin
                next_state = M_HIGH;
            end
        end
        M_HIGH: begin
            if (!m_act) begin
                next_state = M_IDLE;
            end else if (half_end) begin
                m_sample = 1'b1;
                next_state = sh_last ? M_END : M_LOW;
            end
        end
        M_END: begin
            if (!m_act) begin
                next_state = M_IDLE;
            end else if (half_end) begin
                if (!tx_empty) begin
                    m_load = 1'b1;
                    next_state = M_LOW;
                end else begin
                    next_state = M_IDLE;
                end
            end
        end
        default: begin
            next_state = M_IDLE;
        end
    endcase
end

always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        m_state <= M_IDLE;
        m_cnt <= 4'h0;
        sclk_out <= 1'b0;
        ss_out <= 1'b1;
    end else begin
        m_state <= next_state;
        if ((m_state == M_IDLE) || half_end) begin
            m_cnt <= 4'h0;
        end else begin
            m_cnt <= m_cnt + 4'h1;
        end
        sclk_out <= (next_state == M_HIGH);
        ss_out <= (next_state == M_IDLE);
    end
end

// ----------------------------------------
// Slave edge detection
// ----------------------------------------
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        p_sclk <= 1'b0;
        p_ss_n <= 1'b1;
    end else begin
        p_sclk <= s_sclk;
        p_ss_n <= s_ss_n;
    end
end

assign s_load = (s_act && p_ss_n && !s_ss_n) || (sel && sh_done);
assign s_sample = sel && !p_sclk && s_sclk;
assign s_drive = sel && p_sclk && !s_sclk;

// ----------------------------------------
// Shifter
// ----------------------------------------
assign sh_load = m_load || s_load;
assign sh_sample = m_sample || s_sample;
assign sh_drive = m_sample || s_drive;
assign sh_sin = ctrl_mst ? s_miso : s_mosi;

spidb_shift u_shift (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .load(sh_load),
    .din(tx_buf),
    .sample(sh_sample),
    .drive(sh_drive),
    .sin(sh_sin),
    .sout(sh_sout),
    .data(sh_data),
    .last(sh_last),
    .done(sh_done)
);

// ----------------------------------------
// Transmit buffer
// ----------------------------------------
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        tx_buf <= `SPIDB_RST_BYTE;
        tx_empty <= `SPIDB_RST_TXE;
    end else begin
        if (wr_tx) begin
            tx_buf <= WDATA;
            tx_empty <= 1'b0;
        end else if (sh_load) begin
            tx_empty <= 1'b1;
        end
    end
end

// ----------------------------------------
// Receive buffer
// ----------------------------------------
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        rx_buf <= `SPIDB_RST_BYTE;
        rx_full <= `SPIDB_RST_RXF;
    end else begin
        if (sh_done) begin
            rx_buf <= sh_data;
            rx_full <= 1'b1;
        end else if (rd_rx) begin
            rx_full <= 1'b0;
        end else if (wr_rx) begin
            rx_full <= 1'b0;
        end
    end
end

// ----------------------------------------
// Control register
// ----------------------------------------
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        ctrl_en <= `SPIDB_RST_EN;
        ctrl_mst <= `SPIDB_RST_MST;
    end else if (wr_ctrl) begin
        ctrl_en <= WDATA[`SPIDB_CTRL_EN];
        ctrl_mst <= WDATA[`SPIDB_CTRL_MST];
    end
end

assign ctrl_view = {2'h0, busy, rx_full, tx_empty, 1'b0, ctrl_mst, ctrl_en};

// ----------------------------------------
// Interrupts
// ----------------------------------------
assign ev_tx = sh_load && !tx_empty;
assign ev_rx = sh_done;
assign ev_ovr = sh_done && rx_full && !rd_rx && !wr_rx;
assign int_set = {ev_ovr, ev_rx, ev_tx};

always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        int_stat <= `SPIDB_RST_INT;
        int_mask <= `SPIDB_RST_INT;
    end else begin
        if (wr_istat) begin
            int_stat <= (int_stat & ~WDATA[2:0]) | int_set;
        end else begin
            int_stat <= int_stat | int_set;
        end
        if (wr_imask) begin
            int_mask <= WDATA[2:0];
        end
    end
end

assign IRQ = |(int_stat & int_mask);

// ----------------------------------------
// Read data
// ----------------------------------------
always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
        rdata <= 8'h00;
    end else if (RD) begin
        case (ADDR)
            `SPIDB_OFS_RX: rdata <= rx_buf;
            `SPIDB_OFS_CTRL: rdata <= ctrl_view;
            `SPIDB_OFS_ISTAT: rdata <= {5'h00, int_stat};
            `SPIDB_OFS_IMASK: rdata <= {5'h00, int_mask};
            default: rdata <= 8'h00;
        endcase
    end else begin
        rdata <= 8'h00;
    end
end

assign RDATA = rdata;

// ----------------------------------------
// Pin drivers
// ----------------------------------------
assign SCLK_O = sclk_out;
assign SCLK_OE_N = !m_act;
assign MOSI_O = sh_sout;
assign MOSI_OE_N = !m_act;
assign MISO_O = sh_sout;
assign MISO_OE_N = !sel;
assign SS_N_O = ss_out;
assign SS_N_OE_N = !m_act;

endmodule // spidb_top

// [spidb_properties.sv]
// ----------------------------------------
// Port checker
// ----------------------------------------
module spidb_properties (
    input wire CLK_SYS,
    input wire RSTN,
    input wire [7:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [7:0] RDATA,
    input wire IRQ,
    input wire SCLK_O,
    input wire MOSI_O,
    input wire SS_N_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    property p_rd_idle;
        !$past(RD) |-> RDATA == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read cycle");
    property p_tx_ro;
        RD && ADDR == 8'h29 |=> RDATA == 8'h00;
    endproperty
    a_tx_ro: assert property (p_tx_ro)
        else $error("transmit buffer readable");
    property p_unmapped;
        RD && ADDR > 8'h2D |=> RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_sclk_idle;
        SS_N_O |-> !SCLK_O;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("serial clock high outside frame");
    property p_sclk_high;
        $rose(SCLK_O) |=> SCLK_O [*8];
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("serial clock high half too short");
    property p_mosi_stable;
        $rose(SCLK_O) |=> $stable(MOSI_O) [*8];
    endproperty
    a_mosi_stable: assert property (p_mosi_stable)
        else $error("data out changed while clock high");
    property p_ss_frame;
        $fell(SS_N_O) |-> ##[1:12] SCLK_O;
    endproperty
    a_ss_frame: assert property (p_ss_frame)
        else $error("no clock after select");
    property p_irq_mask;
        WR && ADDR == 8'h2D && WDATA[2:0] == 3'h0 |=> !IRQ;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high while all masked");
endmodule // spidb_properties

bind spidb_top spidb_properties u_props (.CLK_SYS, .RSTN, .ADDR, .WDATA,
    .WR, .RD, .RDATA, .IRQ, .SCLK_O, .MOSI_O, .SS_N_O);

// [spidb_peer.sv]
// ----------------------------------------
// Slave peer, mode 0, MSB first
// ----------------------------------------
module spidb_peer (
    input wire sclk,
    input wire ss_n,
    input wire mosi,
    input wire [7:0] reply,
    output reg miso,
    output reg [7:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [7:0] sh;
    integer n;
    initial begin
        sh = 8'h00;
        got = 8'h00;
        n = 0;
    end
    always @(negedge ss_n) begin
        sh = reply;
        n = 0;
    end
    always @(posedge sclk) if (!ss_n) begin
        got = {got[6:0], mosi};
        n = n + 1;
    end
    always @(negedge sclk) if (!ss_n) begin
        if (n == 8) begin
            sh = reply;
            n = 0;
        end else begin
            sh = {sh[6:0], 1'b0};
        end
    end
    // Released line shows inverse value
    always @* miso = ss_n ? ~sh[7] : sh[7];
endmodule // spidb_peer

// [spi_data_buffering_bench.sv]
module spi_data_buffering_bench;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk_sys, rstn, wr, rd;
    reg sclk_i, mosi_i, ss_n_i;
    reg [7:0] addr, wdata, reply, v, so;
    integer errors, samples_checked, cyc;
    wire [7:0] rdata, got;
    wire irq, sclk_o, sclk_oe_n, mosi_o, miso_w, ss_n_o, ss_n_oe_n;
    wire miso_o, miso_oe_n, mosi_oe_n;

    spidb_top uut (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
        .SCLK_I(sclk_i), .SCLK_O(sclk_o), .SCLK_OE_N(sclk_oe_n),
        .MOSI_I(mosi_i), .MOSI_O(mosi_o), .MOSI_OE_N(mosi_oe_n),
        .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_N(miso_oe_n),
        .SS_N_I(ss_n_i), .SS_N_O(ss_n_o),
        .SS_N_OE_N(ss_n_oe_n));
    spidb_peer peer (.sclk(sclk_oe_n ? 1'b0 : sclk_o),
        .ss_n(ss_n_oe_n | ss_n_o), .mosi(mosi_o), .reply(reply),
        .miso(miso_w), .got(got));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task stop_test;
    begin
        $display("errors=%0d checks=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task cmp8(input [7:0] g, input [7:0] e);
    begin
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    task reg_wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
        #1;
    end
    endtask
    task reg_rd(input [7:0] a);
    begin
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 v = rdata;
    end
    endtask
    task wait_rx;
        integer i;
    begin
        v = 8'h00;
        for (i = 0; i < 200 && v[4] !== 1'b1; i = i + 1) reg_rd(8'h2B);
        cmp8(v & 8'h10, 8'h10);
    end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task test_reset;
    begin
        reg_rd(8'h2B);
        cmp8(v, 8'h08);
        reg_rd(8'h29);
        cmp8(v, 8'h00);
        reg_rd(8'h2E);
        cmp8(v, 8'h00);
    end
    endtask
    task test_master;
    begin
        reg_wr(8'h2B, 8'h03);
        cmp8({6'h00, mosi_oe_n, sclk_oe_n}, 8'h00);
        reg_wr(8'h2D, 8'h07);
        reg_wr(8'h29, 8'hA5);
        reg_rd(8'h2B);
        cmp8(v, 8'h2B);
        reg_wr(8'h29, 8'h5A);
        reply = 8'hC3;
        reg_rd(8'h2B);
        cmp8(v, 8'h23);
        wait_rx;
        cmp8(got, 8'hA5);
        reg_rd(8'h2A);
        cmp8(v, 8'h3C);
        reg_rd(8'h2B);
        cmp8(v & 8'h10, 8'h00);
        wait_rx;
        cmp8(got, 8'h5A);
        reg_wr(8'h2A, 8'h00);
        reg_rd(8'h2B);
        cmp8(v & 8'h10, 8'h00);
        reg_rd(8'h2A);
        cmp8(v, 8'hC3);
    end
    endtask
    task test_irq;
    begin
        reg_rd(8'h2C);
        cmp8(v, 8'h03);
        cmp8({7'h00, irq}, 8'h01);
        reg_wr(8'h2D, 8'h00);
        cmp8({7'h00, irq}, 8'h00);
        reg_wr(8'h2D, 8'h07);
        reg_wr(8'h2C, 8'h07);
        reg_rd(8'h2C);
        cmp8(v, 8'h00);
        cmp8({7'h00, irq}, 8'h00);
    end
    endtask
    task slave_byte(input [7:0] d);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1) begin
            @(posedge clk_sys);
            mosi_i <= d[i];
            repeat (6) @(posedge clk_sys);
            sclk_i <= 1'b1;
            repeat (6) @(posedge clk_sys);
            so = {so[6:0], miso_o};
            sclk_i <= 1'b0;
            repeat (5) @(posedge clk_sys);
        end
    end
    endtask
    task test_slave;
    begin
        reg_wr(8'h2B, 8'h01);
        reg_wr(8'h29, 8'h96);
        reg_rd(8'h2B);
        cmp8(v, 8'h01);
        @(posedge clk_sys);
        ss_n_i <= 1'b0;
        repeat (8) @(posedge clk_sys);
        reg_rd(8'h2B);
        cmp8(v, 8'h29);
        cmp8({6'h00, mosi_oe_n, miso_oe_n}, 8'h02);
        reg_wr(8'h29, 8'h4D);
        slave_byte(8'h6C);
        cmp8(so, 8'h96);
        slave_byte(8'h81);
        cmp8(so, 8'h4D);
        @(posedge clk_sys);
        ss_n_i <= 1'b1;
        repeat (8) @(posedge clk_sys);
        reg_rd(8'h2C);
        cmp8(v, 8'h07);
        cmp8({7'h00, irq}, 8'h01);
        reg_rd(8'h2A);
        cmp8(v, 8'h81);
        reg_rd(8'h2B);
        cmp8(v, 8'h09);
    end
    endtask

    // ----------------------------------------
    // Clock, reset, timeout, sequence
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            stop_test;
        end
    end
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        reply = 8'h3C;
        sclk_i = 1'b0;
        mosi_i = 1'b0;
        ss_n_i = 1'b1;
        so = 8'h00;
        errors = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        test_reset;
        test_master;
        test_irq;
        test_slave;
        stop_test;
    end
endmodule // spi_data_buffering_bench
